/* File: hw/npc_regs.svh */
// Register offsets, field positions and reset values of the control slice
`ifndef NPC_REGS_SVH
`define NPC_REGS_SVH
`define NPC_OFF_CMD 8'h88
`define NPC_OFF_PERF 8'h8C
`define NPC_OFF_PM 8'h90
`define NPC_CMD_PAUSE 5
`define NPC_CMD_RTE 4
`define NPC_CMD_DRT_HI 3
`define NPC_CMD_DRT_LO 2
`define NPC_CMD_SOFTWARE_INTERRUPT_BIT 1
`define NPC_CMD_AUTO_UNDERRUN_RECOVERY 0
`define NPC_DRT_RESET 2'h1
`define NPC_DRT_32 2'h0
`define NPC_DRT_64 2'h1
`define NPC_DRT_SF 2'h2
`define NPC_PERF_CLK_HI 31
`define NPC_PERF_CLK_LO 16
`define NPC_PERF_DW_HI 7
`define NPC_PERF_DW_LO 0
`define NPC_PM_STATUS 15
`define NPC_PM_SCALE_HI 14
`define NPC_PM_SCALE_LO 13
`define NPC_PM_SEL_HI 12
`define NPC_PM_SEL_LO 9
`define NPC_PM_ENABLE 8
`endif

/* File: hw/npc_pkg.sv */
// Types shared by the control slice
package npc_pkg;
   typedef enum logic [1:0] {
      NPC_THR_32,
      NPC_THR_64,
      NPC_THR_SF
   } npc_thr_t;
   typedef struct packed {
      logic pause_enable;
      logic auto_underrun_recovery;
      logic software_interrupt_bit;
      npc_thr_t rx_threshold;
   } npc_ctrl_t;
endpackage

/* File: hw/npc_ctrl_regs.sv */
// Command low bits, bus performance counter and power-management status
`timescale 1ns/10ps
`include "npc_regs.svh"
module npc_ctrl_regs #(
   parameter int CLK_W = 16,
   parameter int DW_W = 8
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RESET,
   // Register port
   input wire logic REG_RD,
   input wire logic REG_WR,
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   // Negotiation result
   input wire logic ANEG_DONE,
   input wire logic ANEG_PAUSE,
   // Bus master activity
   input wire logic READ_PENDING,
   input wire logic DWORD_MOVED,
   // Wake
   input wire logic WAKE_EVENT,
   input wire logic WAKE_SIGNAL_ENABLE,
   output logic PME_N,
   // Controls to the datapath
   output npc_pkg::npc_ctrl_t CTRL
);
   logic pause_q;
   logic rte_q;
   logic [1:0] drt_q;
   logic software_interrupt_bit_q;
   logic auto_underrun_recovery_q;
   logic [CLK_W-1:0] clk_cnt_q;
   logic [DW_W-1:0] dw_cnt_q;
   logic wake_status_q;
   logic aneg_done_q;
   logic wr_cmd;
   logic rd_perf;
   logic wr_pm;
   npc_pkg::npc_thr_t thr_d;
   logic wake_clear;
   logic pme_active_d;

   assign wr_cmd = REG_WR && REG_ADDR == `NPC_OFF_CMD;
   assign wr_pm = REG_WR && REG_ADDR == `NPC_OFF_PM;
   assign rd_perf = REG_RD && REG_ADDR == `NPC_OFF_PERF;
   // Only a one written to the status bit clears it; a zero leaves it alone
   assign wake_clear = wr_pm && REG_WDATA[`NPC_PM_STATUS];

   // Pause loads the negotiated result at each completion; a software write overrides it and wins in the same cycle
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         pause_q <= 1'b0;
         aneg_done_q <= 1'b0;
      end else begin
         aneg_done_q <= ANEG_DONE;
         if (wr_cmd) begin
            pause_q <= REG_WDATA[`NPC_CMD_PAUSE];
         end else if (ANEG_DONE && !aneg_done_q) begin
            pause_q <= ANEG_PAUSE;
         end
      end
   end

   // Threshold enable; while off the datapath keeps the fixed 64-byte level
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         rte_q <= 1'b0;
      end else if (wr_cmd) begin
         rte_q <= REG_WDATA[`NPC_CMD_RTE];
      end
   end

   // Drain selection is kept even while the enable is off
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         drt_q <= `NPC_DRT_RESET;
      end else if (wr_cmd) begin
         drt_q <= REG_WDATA[`NPC_CMD_DRT_HI:`NPC_CMD_DRT_LO];
      end
   end

   // Only stored here; whatever acts on it sits outside this slice
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         software_interrupt_bit_q <= 1'b0;
      end else if (wr_cmd) begin
         software_interrupt_bit_q <= REG_WDATA[`NPC_CMD_SOFTWARE_INTERRUPT_BIT];
      end
   end

   // Underrun recovery stays off until software asks for it
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         auto_underrun_recovery_q <= 1'b0;
      end else if (wr_cmd) begin
         auto_underrun_recovery_q <= REG_WDATA[`NPC_CMD_AUTO_UNDERRUN_RECOVERY];
      end
   end

   // Reserved code 11 falls back to 64 bytes rather than an undefined mode
   always_comb begin
      thr_d = npc_pkg::NPC_THR_64;
      if (rte_q) begin
         unique case (drt_q)
            `NPC_DRT_32: thr_d = npc_pkg::NPC_THR_32;
            `NPC_DRT_SF: thr_d = npc_pkg::NPC_THR_SF;
            default: thr_d = npc_pkg::NPC_THR_64;
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         // Enable resets off, so the datapath starts on the 64-byte level
         CTRL.pause_enable <= 1'b0;
         CTRL.auto_underrun_recovery <= 1'b0;
         CTRL.software_interrupt_bit <= 1'b0;
         CTRL.rx_threshold <= npc_pkg::NPC_THR_64;
      end else begin
         CTRL.pause_enable <= pause_q;
         CTRL.auto_underrun_recovery <= auto_underrun_recovery_q;
         CTRL.software_interrupt_bit <= software_interrupt_bit_q;
         CTRL.rx_threshold <= thr_d;
      end
   end

   // A read clears; activity in the read cycle starts the new total
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         clk_cnt_q <= '0;
      end else if (rd_perf) begin
         clk_cnt_q <= CLK_W'(READ_PENDING);
      end else if (READ_PENDING && !(&clk_cnt_q)) begin
         clk_cnt_q <= clk_cnt_q + 1'b1;
      end
   end

   // Saturation keeps a late reader from seeing a small wrapped total
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         dw_cnt_q <= '0;
      end else if (rd_perf) begin
         dw_cnt_q <= DW_W'(DWORD_MOVED);
      end else if (DWORD_MOVED && !(&dw_cnt_q)) begin
         dw_cnt_q <= dw_cnt_q + 1'b1;
      end
   end

   // Set wins over a same-cycle clear so no wake event is lost
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         wake_status_q <= 1'b0;
      end else if (WAKE_EVENT) begin
         wake_status_q <= 1'b1;
      end else if (wake_clear) begin
         wake_status_q <= 1'b0;
      end
   end

   // Pin follows the status while the signal enable is set, but drops in the very cycle of a clearing write
   always_comb begin
      pme_active_d = 1'b0;
      if (WAKE_SIGNAL_ENABLE) begin
         pme_active_d = wake_status_q || WAKE_EVENT;
         if (wake_clear && !WAKE_EVENT) begin
            pme_active_d = 1'b0;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         PME_N <= 1'b1;
      end else begin
         PME_N <= !pme_active_d;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         REG_RDATA <= '0;
      end else begin
         REG_RDATA <= '0;
         if (REG_RD) begin
            unique case (REG_ADDR)
               `NPC_OFF_CMD: begin
                  REG_RDATA[`NPC_CMD_PAUSE] <= pause_q;
                  REG_RDATA[`NPC_CMD_RTE] <= rte_q;
                  REG_RDATA[`NPC_CMD_DRT_HI:`NPC_CMD_DRT_LO] <= drt_q;
                  REG_RDATA[`NPC_CMD_SOFTWARE_INTERRUPT_BIT] <= software_interrupt_bit_q;
                  REG_RDATA[`NPC_CMD_AUTO_UNDERRUN_RECOVERY] <= auto_underrun_recovery_q;
               end
               `NPC_OFF_PERF: begin
                  REG_RDATA[`NPC_PERF_CLK_HI:`NPC_PERF_CLK_LO] <= 16'(clk_cnt_q);
                  REG_RDATA[`NPC_PERF_DW_HI:`NPC_PERF_DW_LO] <= 8'(dw_cnt_q);
               end
               `NPC_OFF_PM: begin
                  REG_RDATA[`NPC_PM_STATUS] <= wake_status_q;
                  REG_RDATA[`NPC_PM_SCALE_HI:`NPC_PM_SCALE_LO] <= 2'h0;
                  REG_RDATA[`NPC_PM_SEL_HI:`NPC_PM_SEL_LO] <= 4'h0;
                  REG_RDATA[`NPC_PM_ENABLE] <= WAKE_SIGNAL_ENABLE;
               end
               default: REG_RDATA <= '0;
            endcase
         end
      end
   end
endmodule

/* File: testbench/npc_sva.sv */
// Checker for the command, counter and wake ports
`timescale 1ns/10ps
module npc_sva (
   // Clock, reset and register port
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic REG_RD,
   input wire logic REG_WR,
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic [31:0] REG_RDATA,
   // Activity, wake and controls
   input wire logic READ_PENDING,
   input wire logic DWORD_MOVED,
   input wire logic WAKE_EVENT,
   input wire logic WAKE_SIGNAL_ENABLE,
   input wire logic PME_N,
   input npc_pkg::npc_ctrl_t CTRL
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RESET);
   wire cw = REG_WR && REG_ADDR == 8'h88;
   wire pr = REG_RD && REG_ADDR == 8'h8C;
   wire qi = !READ_PENDING && !DWORD_MOVED;
   AST_PAUSE: assert property (cw ##1 !REG_WR |=> CTRL.pause_enable == $past(REG_WDATA[5], 2))
      else $error("pause bit wrong");
   AST_RTE_OFF: assert property (cw && !REG_WDATA[4] ##1 !REG_WR |=> CTRL.rx_threshold == 2'h1)
      else $error("threshold not 64");
   AST_DRT: assert property (cw && REG_WDATA[4] && REG_WDATA[3:2] != 2'h3 ##1 !REG_WR |=>
      CTRL.rx_threshold == $past(REG_WDATA[3:2], 2)) else $error("threshold wrong");
   AST_CLR: assert property (pr && qi ##1 !REG_RD && qi ##1 pr |=> REG_RDATA == 32'h0)
      else $error("counter not cleared");
   AST_SCALE: assert property (REG_RD && REG_ADDR == 8'h90 |=> REG_RDATA[14:13] == 2'h0)
      else $error("scale not zero");
   AST_GATE: assert property (!WAKE_SIGNAL_ENABLE |=> PME_N)
      else $error("wake without enable");
   AST_SET: assert property (WAKE_EVENT && WAKE_SIGNAL_ENABLE |=> !PME_N)
      else $error("wake not signalled");
   AST_W1C: assert property (REG_WR && REG_ADDR == 8'h90 && REG_WDATA[15] && !WAKE_EVENT |=> PME_N)
      else $error("wake not released");
   cover property (pr);
   cover property (!PME_N);
   cover property (cw);
   cover property (WAKE_EVENT && REG_WR && REG_ADDR == 8'h90 && REG_WDATA[15]);
endmodule

/* File: testbench/npc_host_model.sv */
// Bus-master activity source on the host side
`timescale 1ns/10ps
module npc_host_model (
   // Clock and start
   input wire logic clk,
   input wire logic go,
   input wire logic [9:0] n,
   // Activity
   output logic rd_pend,
   output logic dw_move
);
   logic [9:0] cnt_q;
   // One dword per pending clock, so both counters see one total until the dword count saturates at 255
   always_ff @(posedge clk) begin
      if (go)
         cnt_q <= n;
      else if (cnt_q != 10'h0)
         cnt_q <= cnt_q - 10'h1;
   end
   assign rd_pend = cnt_q != 10'h0;
   assign dw_move = rd_pend;
endmodule

/* File: testbench/npc_ctrl_regs_tb_top.sv */
// Directed bench for the command, counter and wake registers
`timescale 1ns/10ps
module npc_ctrl_regs_tb_top;
   logic MCLK, RESET, REG_RD, REG_WR, ANEG_DONE, ANEG_PAUSE, WAKE_EVENT, WAKE_SIGNAL_ENABLE;
   logic READ_PENDING, DWORD_MOVED, PME_N, go;
   logic [7:0] REG_ADDR;
   logic [31:0] REG_WDATA, REG_RDATA;
   logic [9:0] n;
   npc_pkg::npc_ctrl_t CTRL;
   int bad_count, check_count;
   npc_ctrl_regs dut (
      .MCLK(MCLK),
      .RESET(RESET),
      .REG_RD(REG_RD),
      .REG_WR(REG_WR),
      .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA),
      .REG_RDATA(REG_RDATA),
      .ANEG_DONE(ANEG_DONE),
      .ANEG_PAUSE(ANEG_PAUSE),
      .READ_PENDING(READ_PENDING),
      .DWORD_MOVED(DWORD_MOVED),
      .WAKE_EVENT(WAKE_EVENT),
      .WAKE_SIGNAL_ENABLE(WAKE_SIGNAL_ENABLE),
      .PME_N(PME_N),
      .CTRL(CTRL)
   );
   npc_host_model host (.clk(MCLK), .go(go), .n(n), .rd_pend(READ_PENDING), .dw_move(DWORD_MOVED));
   initial begin
      MCLK = 1'b0;
      forever #50 MCLK = ~MCLK;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_ctrl(input logic [4:0] got, input logic [4:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: controls %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: wake pin %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge MCLK) REG_WR <= 1'b0;
      @(posedge MCLK);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge MCLK) REG_RD <= 1'b0;
      #1 chk(REG_RDATA, exp);
      @(posedge MCLK);
   endtask
   task automatic run(input logic [9:0] k);
      n <= k;
      go <= 1'b1;
      @(posedge MCLK) go <= 1'b0;
      repeat (k + 2) @(posedge MCLK);
   endtask
   task automatic t_cmd;
      rd(8'h88, 32'h4);
      ANEG_PAUSE <= 1'b1;
      ANEG_DONE <= 1'b1;
      repeat (2) @(posedge MCLK);
      rd(8'h88, 32'h24);
      wr(8'h88, 32'h13);
      rd(8'h88, 32'h13);
      chk_ctrl(CTRL, 5'h0C);
      for (int d = 0; d < 3; d++) begin
         wr(8'h88, 32'h10 | (d << 2));
         @(posedge MCLK);
         chk_ctrl(CTRL, 5'(d));
      end
      wr(8'h88, 32'h8);
      @(posedge MCLK);
      chk_ctrl(CTRL, 5'h01);
   endtask
   task automatic t_perf;
      rd(8'h8C, 32'h0);
      run(10'd20);
      rd(8'h8C, 32'h0014_0014);
      rd(8'h8C, 32'h0);
      run(10'd300);
      rd(8'h8C, 32'h012C_00FF);
   endtask
   task automatic t_wake;
      WAKE_EVENT <= 1'b1;
      @(posedge MCLK) WAKE_EVENT <= 1'b0;
      rd(8'h90, 32'h8000);
      chk_pin(PME_N, 1'b1);
      WAKE_SIGNAL_ENABLE <= 1'b1;
      repeat (2) @(posedge MCLK);
      chk_pin(PME_N, 1'b0);
      wr(8'h90, 32'h0);
      rd(8'h90, 32'h8100);
      wr(8'h90, 32'hFE00);
      chk_pin(PME_N, 1'b1);
      rd(8'h90, 32'h100);
      // Wake event and clearing write in one cycle: the event must win
      WAKE_EVENT <= 1'b1;
      REG_WR <= 1'b1;
      REG_ADDR <= 8'h90;
      REG_WDATA <= 32'h8000;
      @(posedge MCLK);
      WAKE_EVENT <= 1'b0;
      REG_WR <= 1'b0;
      @(posedge MCLK);
      chk_pin(PME_N, 1'b0);
      rd(8'h90, 32'h8100);
      wr(8'h90, 32'h8000);
      chk_pin(PME_N, 1'b1);
      rd(8'h90, 32'h100);
   endtask
   task automatic give_verdict;
      $display("Checks %0d, errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      {REG_RD, REG_WR, ANEG_DONE, ANEG_PAUSE, WAKE_EVENT, WAKE_SIGNAL_ENABLE} = '0;
      {RESET, go, REG_ADDR, REG_WDATA, n} = {2'h3, 50'h0};
      repeat (12) @(posedge MCLK);
      RESET <= 1'b0;
      go <= 1'b0;
      @(posedge MCLK);
      t_cmd();
      t_perf();
      t_wake();
      give_verdict();
   end
   initial begin
      #200000;
      bad_count++;
      give_verdict();
   end
endmodule
bind npc_ctrl_regs npc_sva u_sva (
   .MCLK(MCLK),
   .RESET(RESET),
   .REG_RD(REG_RD),
   .REG_WR(REG_WR),
   .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA),
   .REG_RDATA(REG_RDATA),
   .READ_PENDING(READ_PENDING),
   .DWORD_MOVED(DWORD_MOVED),
   .WAKE_EVENT(WAKE_EVENT),
   .WAKE_SIGNAL_ENABLE(WAKE_SIGNAL_ENABLE),
   .PME_N(PME_N),
   .CTRL(CTRL)
);
